// ### pkg/psc_pkg.sv
// Purpose : constants, field layouts and types of the power-on strap loader
// Assumes : one 250 MHz clock, AHB-Lite register access, 32-bit words
// Notes   : all offsets are byte addresses of aligned words

package psc_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0]  OFS_STRAP   = 8'h00;   // raw captured word, read only
   localparam logic [7:0]  OFS_DECODE  = 8'h04;   // decoded settings, read only
   localparam logic [7:0]  OFS_CTRL    = 8'h08;   // control, read/write
   localparam logic [7:0]  OFS_SUBSYS  = 8'h0C;   // subsystem vendor and id

   // ************************************************************
   // strap word field positions
   // ************************************************************
   localparam int STRAP_W    = 10;   // width of the strap word
   localparam int B_PCIREV   = 9;    // bus revision select
   localparam int B_TV_HI    = 8;    // tv format, upper bit
   localparam int B_TV_LO    = 7;    // tv format, lower bit
   localparam int B_XTAL     = 6;    // crystal select
   localparam int B_HOST     = 5;    // host bus select
   localparam int B_WIDTH    = 4;    // framebuffer width
   localparam int B_MEM_HI   = 3;    // memory type, upper bit
   localparam int B_MEM_LO   = 2;    // memory type, lower bit
   localparam int B_SUBSRC   = 1;    // subsystem id source
   localparam int B_FAST     = 0;    // fast bus capable

   // status bit positions in the strap register
   localparam int B_VALID    = 31;   // capture done
   localparam int B_BADCFG   = 30;   // agp without fast strap
   localparam int B_RSVD     = 29;   // reserved tv or memory code
   localparam int B_ROMDONE  = 28;   // subsystem ids loaded from rom
   // control bit positions
   localparam int B_FBREL    = 0;    // release held framebuffer pins

   // ************************************************************
   // field codes
   // ************************************************************
   localparam logic [1:0] TV_NTSC = 2'h1;   // ntsc timing
   localparam logic [1:0] TV_PAL  = 2'h2;   // pal timing
   localparam logic [1:0] TV_OFF  = 2'h3;   // tv disabled
   localparam logic [1:0] MEM_NRM = 2'h1;   // normal memory mode
   localparam logic [1:0] MEM_TRI = 2'h3;   // memory pins held tri-state

   // ************************************************************
   // values and timing
   // ************************************************************
   localparam logic [4:0]  TGT_LAT_CLKS = 5'h10;        // target latency limit, 16
   localparam logic [23:0] XTAL_LO_HZ   = 24'hCD_FE60;  // 13.500 MHz
   localparam logic [23:0] XTAL_HI_HZ   = 24'hDA_7A64;  // 14.31818 MHz
   localparam logic [1:0]  SYNC_FILL    = 2'h3;         // edges to fill synchroniser
   localparam logic [7:0]  ROM_SUB_BASE = 8'h54;        // first subsystem byte in rom
   localparam logic [1:0]  ROM_LAST     = 2'h3;         // index of last byte, 0x57
   localparam logic [31:0] SUBSYS_RST   = 32'h0000_0000; // ids when firmware owns them
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000; // control reset value

   // rom fetch states, one-hot
   typedef enum logic [3:0] {
      RF_IDLE = 4'h1,
      RF_REQ  = 4'h2,
      RF_NEXT = 4'h4,
      RF_DONE = 4'h8
   } psc_rf_t;

endpackage : psc_pkg

// ### rtl/psc_top.sv
// Purpose : capture the board strap word at power-on and decode device settings
// Assumes : hresetn is the power-on reset; strap pins settle before its release
// Notes   : strap pins are asynchronous and pass a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none

module psc_top (
   input  wire logic        hclk,                 // 250 MHz clock
   input  wire logic        hresetn,              // power-on reset, active low
   // ahb-lite slave
   input  wire logic        hsel,                 // slave select
   input  wire logic [31:0] haddr,                // byte address
   input  wire logic [1:0]  htrans,               // transfer type
   input  wire logic        hwrite,               // write when high
   input  wire logic [2:0]  hsize,                // transfer size
   input  wire logic [31:0] hwdata,               // write data
   input  wire logic        hready,               // bus ready
   output logic [31:0]      hrdata,               // read data
   output logic             hreadyout,            // slave ready
   output logic             hresp,                // always okay
   // strap pins
   input  wire logic [9:0]  strap_address_pins,   // board pull resistors
   // boot rom byte port
   output logic             rom_rd_req,           // byte read request
   output logic [7:0]       rom_rd_addr,          // byte address
   input  wire logic        rom_rd_valid,         // byte returned
   input  wire logic [7:0]  rom_rd_data,          // returned byte
   // pin enables, low while driving
   output logic             sysbus_oe_n,          // system bus interface
   output logic             fb_hi_oe_n,           // upper 64 data lines and selects
   output logic             fb_io_oe_n,           // framebuffer i/o pins
   // decoded settings
   output logic             cfg_valid,            // capture done
   output logic             pci21_mode,           // delayed transactions on
   output logic [4:0]       tgt_lat_limit,        // target latency limit, clocks
   output logic [1:0]       tv_format,            // tv timing code
   output logic             tv_enable,            // tv output allowed
   output logic [23:0]      ref_clk_hz,           // reference crystal frequency
   output logic             host_is_agp,          // agp host bus
   output logic             fb_width_128,         // 128-bit framebuffer
   output logic [1:0]       mem_type,             // memory type code
   output logic             fast_bus_capable_flag, // reported 66 MHz capability
   output logic [15:0]      subsys_vendor,        // subsystem vendor id
   output logic [15:0]      subsys_id             // subsystem id
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [9:0]   sync1_r;        // synchroniser first stage
   logic [9:0]   sync2_r;        // second stage
   logic [9:0]   sync3_r;        // third stage
   logic [1:0]   fill_r;         // edges since reset release
   logic [9:0]   cfg_r;          // captured strap word
   logic         valid_r;        // capture done
   logic         cap_go;         // capture in this cycle
   logic [31:0]  ctrl_r;         // control register
   logic [31:0]  subsys_r;       // subsystem ids
   logic         romdone_r;      // rom load finished
   psc_pkg::psc_rf_t rf_r;       // rom fetch state
   logic [1:0]   rf_idx_r;       // byte index
   logic         oe_sys_n_r;     // system bus enable
   logic         oe_hi_n_r;      // upper lane enable
   logic         oe_io_n_r;      // framebuffer io enable
   logic         dp_wr_r;        // data phase write pending
   logic [1:0]   dp_sel_r;       // data phase register
   logic         dp_hit_r;       // data phase is mapped
   logic [31:0]  rdata_r;        // read data register
   logic         ap_go;          // address phase taken
   logic [2:0]   ap_slot;        // slot of the address in the address phase
   logic         bad_cfg;        // agp without fast strap
   logic         rsvd_code;      // reserved code strapped

   // ************************************************************
   // functions
   // ************************************************************
   // map a byte address to a register slot, bit 2 = hit
   function automatic logic [2:0] reg_slot(input logic [31:0] a);
      logic [2:0] s;
      s = 3'h0;
      case (a[7:0])
         psc_pkg::OFS_STRAP  : s = 3'h4;
         psc_pkg::OFS_DECODE : s = 3'h5;
         psc_pkg::OFS_CTRL   : s = 3'h6;
         psc_pkg::OFS_SUBSYS : s = 3'h7;
         default             : s = 3'h0;
      endcase
      if (a[31:8] != 24'h00_0000) begin
         s = 3'h0;
      end
      return s;
   endfunction : reg_slot

   // ************************************************************
   // strap synchroniser and capture
   // ************************************************************
   // three stages; only the second and third are compared
   // reset clears the chain, so no word is taken before release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 10'h000;
         sync2_r <= 10'h000;
         sync3_r <= 10'h000;
      end else begin
         sync1_r <= strap_address_pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // count edges after release until the chain holds pin values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fill_r <= 2'h0;
      end else if (fill_r != psc_pkg::SYNC_FILL) begin
         fill_r <= fill_r + 2'h1;
      end
   end

   // first stable word after the reset edge is taken
   assign cap_go = !valid_r && (fill_r == psc_pkg::SYNC_FILL) && (sync2_r == sync3_r);

   // capture once, hold until the next power-on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r   <= 10'h000;
         valid_r <= 1'b0;
      end else if (cap_go) begin
         cfg_r   <= sync3_r;
         valid_r <= 1'b1;
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   // fields come straight from the captured flops, so they never
   // glitch once capture is done
   assign cfg_valid     = valid_r;
   assign pci21_mode    = cfg_r[psc_pkg::B_PCIREV];
   assign tgt_lat_limit = pci21_mode ? psc_pkg::TGT_LAT_CLKS : 5'h00;
   assign tv_format     = cfg_r[psc_pkg::B_TV_HI:psc_pkg::B_TV_LO];
   assign tv_enable     = valid_r && (tv_format == psc_pkg::TV_NTSC
                                      || tv_format == psc_pkg::TV_PAL);
   assign ref_clk_hz    = cfg_r[psc_pkg::B_XTAL] ? psc_pkg::XTAL_HI_HZ
                                                 : psc_pkg::XTAL_LO_HZ;
   assign host_is_agp   = cfg_r[psc_pkg::B_HOST];
   assign fb_width_128  = cfg_r[psc_pkg::B_WIDTH];
   assign mem_type      = cfg_r[psc_pkg::B_MEM_HI:psc_pkg::B_MEM_LO];
   assign fast_bus_capable_flag = cfg_r[psc_pkg::B_FAST];
   assign bad_cfg       = valid_r && host_is_agp && !fast_bus_capable_flag;
   assign rsvd_code     = valid_r && (tv_format == 2'h0 || !mem_type[0]);
   assign subsys_vendor = subsys_r[15:0];
   assign subsys_id     = subsys_r[31:16];

   // ************************************************************
   // pin enables
   // ************************************************************
   // every enable stays high (undriven) until capture is done
   // registered, so a pin never sees a decode glitch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe_sys_n_r <= 1'b1;
         oe_hi_n_r  <= 1'b1;
         oe_io_n_r  <= 1'b1;
      end else begin
         oe_sys_n_r <= !valid_r;
         oe_hi_n_r  <= !(valid_r && fb_width_128);
         oe_io_n_r  <= !(valid_r && (mem_type != psc_pkg::MEM_TRI
                                     || ctrl_r[psc_pkg::B_FBREL]));
      end
   end
   assign sysbus_oe_n = oe_sys_n_r;
   assign fb_hi_oe_n  = oe_hi_n_r;
   assign fb_io_oe_n  = oe_io_n_r;

   // ************************************************************
   // subsystem id fetch from boot rom
   // ************************************************************
   // one byte at a time, 0x54 upward, little-endian into subsys_r
   // runs once per reset; the done state is a sink
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rf_r     <= psc_pkg::RF_IDLE;
         rf_idx_r <= 2'h0;
      end else begin
         case (rf_r)
            psc_pkg::RF_IDLE : begin
               if (valid_r && cfg_r[psc_pkg::B_SUBSRC]) begin
                  rf_r <= psc_pkg::RF_REQ;
               end
            end
            psc_pkg::RF_REQ : begin
               if (rom_rd_valid) begin
                  rf_r <= psc_pkg::RF_NEXT;
               end
            end
            psc_pkg::RF_NEXT : begin
               if (rf_idx_r == psc_pkg::ROM_LAST) begin
                  rf_r <= psc_pkg::RF_DONE;
               end else begin
                  rf_idx_r <= rf_idx_r + 2'h1;
                  rf_r     <= psc_pkg::RF_REQ;
               end
            end
            psc_pkg::RF_DONE : begin
               rf_r <= psc_pkg::RF_DONE;
            end
            default : begin
               rf_r <= psc_pkg::RF_IDLE;
            end
         endcase
      end
   end
   assign rom_rd_req  = (rf_r == psc_pkg::RF_REQ);
   assign rom_rd_addr = psc_pkg::ROM_SUB_BASE + {6'h00, rf_idx_r};

   // rom done flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         romdone_r <= 1'b0;
      end else if (rf_r == psc_pkg::RF_DONE) begin
         romdone_r <= 1'b1;
      end
   end

   // ids: rom bytes when sourced from rom, firmware writes otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         subsys_r <= psc_pkg::SUBSYS_RST;
      end else if (rom_rd_req && rom_rd_valid) begin
         subsys_r[8*rf_idx_r +: 8] <= rom_rd_data;
      end else if (dp_wr_r && dp_hit_r && dp_sel_r == 2'h3
                   && valid_r && !cfg_r[psc_pkg::B_SUBSRC]) begin
         subsys_r <= hwdata;
      end
   end

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   // zero wait states, okay response always
   assign ap_go     = hsel && htrans[1] && hready;
   assign ap_slot   = reg_slot(haddr);   // decoded once for the data phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // a read right behind a write to the same register sees the old
   // value, because the write lands only in its data phase
   // latch address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r  <= 1'b0;
         dp_sel_r <= 2'h0;
         dp_hit_r <= 1'b0;
      end else begin
         dp_wr_r  <= ap_go && hwrite;
         dp_sel_r <= ap_slot[1:0];
         dp_hit_r <= ap_go && ap_slot[2];
      end
   end

   // control register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= psc_pkg::CTRL_RST;
      end else if (dp_wr_r && dp_hit_r && dp_sel_r == 2'h2) begin
         ctrl_r <= {31'h0000_0000, hwdata[psc_pkg::B_FBREL]};
      end
   end

   // read data sampled in the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (ap_go && !hwrite) begin
         case (reg_slot(haddr))
            3'h4    : rdata_r <= {valid_r, bad_cfg, rsvd_code, romdone_r,
                                  18'h0_0000, cfg_r};
            3'h5    : rdata_r <= {ref_clk_hz, 1'b0, pci21_mode, tv_enable,
                                  host_is_agp, fb_width_128,
                                  fast_bus_capable_flag, mem_type};
            3'h6    : rdata_r <= ctrl_r;
            3'h7    : rdata_r <= subsys_r;
            default : rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = rdata_r;

   // ************************************************************
   // assertions
   // ************************************************************
   // all on hclk, quiet while power-on reset is low
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_cap;
      !valid_r ##1 valid_r;
   endsequence

   // byte taken, request low one cycle, then the next address
   sequence s_rom_step;
      !rom_rd_req ##1 rom_rd_req && rom_rd_addr == 8'h55;
   endsequence

   chk_cap_takes_word : assert property (cap_go |=> cfg_r == $past(sync3_r))
      else $error("captured word differs from synchronised strap");
   chk_bus_held_off : assert property (!valid_r |=> sysbus_oe_n)
      else $error("system bus driven before capture");
   chk_bus_released : assert property (s_cap |=> !sysbus_oe_n)
      else $error("system bus not released after capture");
   chk_latency_set : assert property (tgt_lat_limit == (pci21_mode ? 5'h10 : 5'h00))
      else $error("target latency limit wrong");
   chk_tv_decode : assert property (tv_enable |-> tv_format != 2'h3 && tv_format != 2'h0)
      else $error("tv enabled for off or reserved code");
   chk_xtal_value : assert property (cfg_r[6] |-> ref_clk_hz == 24'hDA_7A64)
      else $error("reference frequency mismatch");
   chk_agp_flag : assert property (valid_r && cfg_r[5] && !cfg_r[0] |-> bad_cfg)
      else $error("agp without fast strap not flagged");
   chk_upper_lane : assert property (valid_r && !fb_width_128 |=> fb_hi_oe_n[*3])
      else $error("upper lanes driven in 64-bit mode");
   chk_width_drive : assert property (valid_r && fb_width_128 |=> !fb_hi_oe_n)
      else $error("upper lanes not driven in 128-bit mode");
   chk_mem_tri : assert property (mem_type == 2'h3 && !ctrl_r[0] |=> fb_io_oe_n)
      else $error("framebuffer pins driven while held");
   chk_io_release : assert property (valid_r && mem_type == 2'h3 && ctrl_r[0]
                                      |=> !fb_io_oe_n)
      else $error("framebuffer pins not released by control");
   chk_bios_ids : assert property (valid_r && !cfg_r[1] |-> !rom_rd_req)
      else $error("rom read with firmware-owned ids");
   chk_rom_fetch : assert property (rom_rd_req && rom_rd_valid && rf_idx_r == 2'h0
                                     |=> s_rom_step)
      else $error("rom fetch did not advance");
   chk_rom_done : assert property (rf_r == psc_pkg::RF_DONE |=> romdone_r)
      else $error("rom load not reported done");
   chk_fast_flag : assert property (fast_bus_capable_flag == cfg_r[0])
      else $error("fast bus flag not from strap");
   chk_cfg_hold : assert property (valid_r |=> $stable(cfg_r) && valid_r)
      else $error("captured settings changed");

endmodule : psc_top

`default_nettype wire

// ### bench/psc_rom_model.sv
// Purpose : boot rom byte source behind the strap loader
// Assumes : one byte per request, answered promptly and slowly in turn
// Notes   : returned byte is {addr[3:0], ~addr[3:0]}; data toggles when idle
`timescale 1ns/1ps
`default_nettype none

module psc_rom_model (
   input  wire logic       hclk,          // 250 MHz clock
   input  wire logic       hresetn,       // power-on reset, active low
   input  wire logic       rom_rd_req,    // byte read request
   input  wire logic [7:0] rom_rd_addr,   // byte address
   output logic            rom_rd_valid,  // byte returned, one cycle
   output logic [7:0]      rom_rd_data    // returned byte
);
   logic [1:0] wait_r;   // cycles waited on a slow answer
   logic       slow_r;   // answer slowly this time

   // ************************************************************
   // byte answer
   // ************************************************************
   // alternate prompt and four-cycle answers; data never holds when idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rom_rd_valid <= 1'b0;
         rom_rd_data  <= 8'h00;
         wait_r       <= 2'h0;
         slow_r       <= 1'b0;
      end else if (rom_rd_valid) begin  // one-cycle answer done
         rom_rd_valid <= 1'b0;
         rom_rd_data  <= ~rom_rd_data;
         slow_r       <= ~slow_r;
         wait_r       <= 2'h0;
      end else if (rom_rd_req && (!slow_r || wait_r == 2'h3)) begin
         rom_rd_valid <= 1'b1;
         rom_rd_data  <= {rom_rd_addr[3:0], ~rom_rd_addr[3:0]};
      end else begin  // waiting or idle
         wait_r      <= rom_rd_req ? wait_r + 2'h1 : 2'h0;
         rom_rd_data <= ~rom_rd_data;
      end
   end
endmodule : psc_rom_model
`default_nettype wire

// ### bench/tb_top.sv
// Purpose : self-checking bench of the power-on strap loader
// Assumes : zero-wait ahb-lite slave, strap stable through reset
// Notes   : each strap word is applied under a fresh power-on reset
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // bus control
   logic [1:0]  htrans;                                          // transfer type
   logic [2:0]  hsize;                                           // transfer size
   logic [31:0] haddr, hwdata, hrdata;                           // bus data
   logic [9:0]  strap;                                           // strap pins
   logic        rom_rd_req, rom_rd_valid;                        // rom handshake
   logic [7:0]  rom_rd_addr, rom_rd_data;                        // rom byte port
   logic        sysbus_oe_n, fb_hi_oe_n, fb_io_oe_n, cfg_valid;  // enables, done
   logic        pci21_mode, tv_enable, host_is_agp, fb_width_128, fast_flag;
   logic [4:0]  tgt_lat_limit;                                   // latency limit
   logic [1:0]  tv_format, mem_type;                             // codes
   logic [23:0] ref_clk_hz;                                      // crystal
   logic [15:0] subsys_vendor, subsys_id;                        // subsystem ids
   int          miscompares, checks_done, cycles;                // bookkeeping

   psc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .strap_address_pins(strap), .rom_rd_req(rom_rd_req), .rom_rd_addr(rom_rd_addr),
      .rom_rd_valid(rom_rd_valid), .rom_rd_data(rom_rd_data),
      .sysbus_oe_n(sysbus_oe_n), .fb_hi_oe_n(fb_hi_oe_n), .fb_io_oe_n(fb_io_oe_n),
      .cfg_valid(cfg_valid), .pci21_mode(pci21_mode), .tgt_lat_limit(tgt_lat_limit),
      .tv_format(tv_format), .tv_enable(tv_enable), .ref_clk_hz(ref_clk_hz),
      .host_is_agp(host_is_agp), .fb_width_128(fb_width_128), .mem_type(mem_type),
      .fast_bus_capable_flag(fast_flag), .subsys_vendor(subsys_vendor),
      .subsys_id(subsys_id));
   psc_rom_model rom_u (.hclk(hclk), .hresetn(hresetn), .rom_rd_req(rom_rd_req),
      .rom_rd_addr(rom_rd_addr), .rom_rd_valid(rom_rd_valid), .rom_rd_data(rom_rd_data));

   // ************************************************************
   // clock, timeout and shared tasks
   // ************************************************************
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // single ahb-lite transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // ************************************************************
   // one strap word under a fresh power-on reset
   // ************************************************************
   task automatic run_cfg(input logic [9:0] w);
      logic [31:0] d;
      int          n;
      @(posedge hclk);
      hresetn <= 1'b0;
      strap   <= w;
      repeat (6) @(posedge hclk);
      #1 chk("sysbus_oe_n in reset", 32'h0000_0001, sysbus_oe_n);
      @(posedge hclk) hresetn <= 1'b1;
      n = 0;
      while (cfg_valid !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      repeat (2) @(posedge hclk);
      #1 chk("sysbus_oe_n", 32'h0000_0000, sysbus_oe_n);
      chk("pci21_mode", w[9], pci21_mode);
      chk("tgt_lat_limit", w[9] ? psc_pkg::TGT_LAT_CLKS : 5'h00, tgt_lat_limit);
      chk("tv_format", w[8:7], tv_format);
      chk("tv_enable", w[8] ^ w[7], tv_enable);
      chk("ref_clk_hz", w[6] ? psc_pkg::XTAL_HI_HZ : psc_pkg::XTAL_LO_HZ, ref_clk_hz);
      chk("host_is_agp", w[5], host_is_agp);
      chk("fb_width_128", w[4], fb_width_128);
      chk("fb_hi_oe_n", !w[4], fb_hi_oe_n);
      chk("mem_type", w[3:2], mem_type);
      if (w[2]) chk("fb_io_oe_n", w[3], fb_io_oe_n);
      chk("fast_flag", w[0], fast_flag);
      ahb(1'b0, {24'h00_0000, psc_pkg::OFS_STRAP}, 32'h0000_0000, d);
      chk("strap reg", {1'b1, w[5] & ~w[0], (w[8:7] == 2'h0) | ~w[2], 19'h0_0000, w},
          d & 32'hE000_03FF);
      ahb(1'b0, {24'h00_0000, psc_pkg::OFS_DECODE}, 32'h0000_0000, d);
      chk("decode reg", {w[6] ? psc_pkg::XTAL_HI_HZ : psc_pkg::XTAL_LO_HZ, 1'b0, w[9],
          w[8] ^ w[7], w[5], w[4], w[0], w[3:2]}, d);
      if (w[3:2] == psc_pkg::MEM_TRI) begin
         ahb(1'b1, {24'h00_0000, psc_pkg::OFS_CTRL}, 32'h0000_0001, d);
         repeat (2) @(posedge hclk);
         #1 chk("fb_io_oe_n released", 32'h0000_0000, fb_io_oe_n);
      end
      if (w[1]) begin
         repeat (40) @(posedge hclk);
         #1 chk("subsys_vendor", 32'h0000_5A4B, subsys_vendor);
         chk("subsys_id", 32'h0000_7869, subsys_id);
      end else begin
         chk("subsys ids", 32'h0000_0000, {subsys_id, subsys_vendor});
         ahb(1'b1, {24'h00_0000, psc_pkg::OFS_SUBSYS}, 32'h1234_5678, d);
         ahb(1'b0, {24'h00_0000, psc_pkg::OFS_SUBSYS}, 32'h0000_0000, d);
         chk("subsys reg", 32'h1234_5678, d);
      end
      @(posedge hclk) strap <= ~w;
      repeat (8) @(posedge hclk);
      ahb(1'b0, {24'h00_0000, psc_pkg::OFS_STRAP}, 32'h0000_0000, d);
      chk("held word", w, d[9:0]);
      chk("rom ids loaded", w[1], d[28]);
      chk("held tv_format", w[8:7], tv_format);
   endtask : run_cfg

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [31:0] d;
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0000_0000;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0000_0000;
      strap   = 10'h000;
      repeat (6) @(posedge hclk);
      run_cfg(10'h2B7);
      run_cfg(10'h14C);
      run_cfg(10'h395);
      run_cfg(10'h068);
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000, d);
      chk("unmapped read", 32'h0000_0000, d);
      chk("hresp", 32'h0000_0000, hresp);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
